// ==== rtl/cand_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface cand_if #(parameter int ID_W = 8, parameter int N = 8);
  logic            clr;
  logic            add;
  logic [ID_W-1:0] add_id;
  logic            next;
  logic            valid;
  logic [ID_W-1:0] cur_id;
  logic            empty;
  modport owner (output clr, add, add_id, next, input valid, cur_id, empty);
  modport store (input clr, add, add_id, next, output valid, cur_id, empty);
endinterface
`default_nettype wire

// ==== rtl/cand_set.sv ====
`timescale 1ns/100ps
`default_nettype none
// Candidate upstream channel id set
module cand_set #(
  parameter int ID_W = 8,
  parameter int N    = 8
) (
  // System
  input  wire logic clock,
  input  wire logic reset_n,
  // Set access
  cand_if.store     c
);
  typedef struct packed {
    logic [N-1:0][ID_W-1:0] ids;
    logic [N-1:0]           used;
    logic [$clog2(N+1)-1:0] cnt;
    logic [$clog2(N+1)-1:0] ptr;
  } set_t;
  set_t s_q, s_d;
  logic dup;

  always_comb begin
    s_d = s_q;
    dup = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (s_q.used[i] && s_q.ids[i] == c.add_id) begin
        dup = 1'b1;
      end
    end
    if (c.clr) begin
      s_d.used = '0;
      s_d.cnt  = '0;
      s_d.ptr  = '0;
    end else begin
      // distinct ids only; full set drops extras
      if (c.add && !dup && s_q.cnt < N) begin
        s_d.ids[s_q.cnt[$clog2(N)-1:0]]  = c.add_id;
        s_d.used[s_q.cnt[$clog2(N)-1:0]] = 1'b1;
        s_d.cnt = s_q.cnt + 1'b1;
      end
      if (c.next && s_q.ptr < s_q.cnt) begin
        s_d.ptr = s_q.ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign c.valid  = s_q.ptr < s_q.cnt;
  assign c.empty  = s_q.cnt == '0;
  assign c.cur_id = s_q.ids[s_q.ptr[$clog2(N)-1:0]];

  property p_no_dup;
    @(posedge clock) disable iff (!reset_n)
      (c.add && dup && !c.clr) |=> (s_q.cnt == $past(s_q.cnt));
  endproperty
  a_no_dup: assert property (p_no_dup) else $error("duplicate id added");
endmodule
`default_nettype wire

// ==== rtl/init_seq_consts.svh ====
`ifndef INIT_SEQ_CONSTS_SVH
`define INIT_SEQ_CONSTS_SVH
`define CLK_MHZ          40
`define UCD_WAIT_MS      2000
`define T3_MS            200
`define T4_MS            35000
`define T3_LIMIT         5'h10
`define CHAN_STEP_KHZ    6000
`define MS_TO_CYC(ms)    ((ms) * 1000 * `CLK_MHZ)
`endif

// ==== rtl/init_seq_pkg.sv ====
package init_seq_pkg;
  typedef enum logic [9:0] {
    ST_STORED  = 10'b00_0000_0001,
    ST_SCAN    = 10'b00_0000_0010,
    ST_WAITUCD = 10'b00_0000_0100,
    ST_PICK    = 10'b00_0000_1000,
    ST_SYNCTS  = 10'b00_0001_0000,
    ST_WAITMAP = 10'b00_0010_0000,
    ST_RANGE   = 10'b00_0100_0000,
    ST_UPPER   = 10'b00_1000_0000,
    ST_OPER    = 10'b01_0000_0000,
    ST_RESYNC  = 10'b10_0000_0000
  } phase_t;
endpackage

// ==== rtl/modem_init_sequencer.sv ====
`include "init_seq_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module modem_init_sequencer #(
  parameter int          ID_W      = 8,
  parameter int          N_CAND    = 8,
  parameter int          FREQ_W    = 20,
  parameter int          TMR_W     = 32,
  parameter logic [31:0] UCD_CYC   = 32'(`MS_TO_CYC(`UCD_WAIT_MS)),
  parameter logic [31:0] T3_CYC    = 32'(`MS_TO_CYC(`T3_MS)),
  parameter logic [31:0] T4_CYC    = 32'(`MS_TO_CYC(`T4_MS)),
  parameter logic [FREQ_W-1:0] BAND_LO  = 20'h0_0000,
  parameter logic [FREQ_W-1:0] BAND_HI  = 20'h0_FFFF,
  parameter logic [47:0] MAC_ADDR  = 48'h0200_0000_0001 // arbitrary
) (
  // System
  input  wire logic              clock,
  input  wire logic              reset_n,
  // Non-volatile store
  input  wire logic [FREQ_W-1:0] nv_freq,
  input  wire logic              nv_valid,
  output logic                   nv_write,
  output logic [FREQ_W-1:0]      nv_wr_freq,
  // Tuner and lock status
  output logic [FREQ_W-1:0]      tune_freq,
  output logic                   tune_go,
  input  wire logic              tune_done,
  input  wire logic              qam_lock,
  input  wire logic              fec_lock,
  input  wire logic              mpeg_lock,
  // Downstream MAC messages
  input  wire logic              sync_seen,
  input  wire logic              ucd_seen,
  input  wire logic [ID_W-1:0]   ucd_chan_id,
  input  wire logic              ucd_usable,
  input  wire logic              map_seen,
  input  wire logic [ID_W-1:0]   map_chan_id,
  // Ranging and later phases
  input  wire logic              range_ok,
  input  wire logic              range_fail,
  input  wire logic              t3_restart,
  input  wire logic              t4_restart,
  input  wire logic              upper_done,
  // Status
  output logic [ID_W-1:0]        us_chan_id,
  output logic                   ucd_extract,
  output logic                   tx_allow,
  output logic                   range_start,
  output logic                   upper_start,
  output logic                   scanning,
  output logic                   operational,
  output logic [47:0]            mac_addr
);
  typedef struct packed {
    init_seq_pkg::phase_t  ph;
    logic [FREQ_W-1:0]     freq;
    logic                  tuning;
    logic                  time_ref;
    logic [4:0]            t3_cnt;
    logic [ID_W-1:0]       chan;
    logic                  nv_write;
    logic                  extract;
    logic                  tx_allow;
    logic                  range_go;
    logic                  upper_go;
    logic                  tune_go;
    logic [47:0]           mac;
  } seq_t;
  seq_t s_q, s_d;

  cand_if #(.ID_W(ID_W), .N(N_CAND)) cif ();
  logic ucd_exp, t3_exp, t4_exp;
  logic ucd_start, t3_start, t4_start, tmr_stop;
  logic ds_valid;

  cand_set #(.ID_W(ID_W), .N(N_CAND)) u_cand (
    .clock   (clock),
    .reset_n (reset_n),
    .c       (cif.store)
  );

  phase_timer #(.W(TMR_W)) u_ucd_tmr (
    .clock   (clock),
    .reset_n (reset_n),
    .start   (ucd_start),
    .stop    (tmr_stop),
    .load    (UCD_CYC),
    .expired (ucd_exp)
  );

  phase_timer #(.W(TMR_W)) u_t3_tmr (
    .clock   (clock),
    .reset_n (reset_n),
    .start   (t3_start),
    .stop    (tmr_stop),
    .load    (T3_CYC),
    .expired (t3_exp)
  );

  phase_timer #(.W(TMR_W)) u_t4_tmr (
    .clock   (clock),
    .reset_n (reset_n),
    .start   (t4_start),
    .stop    (tmr_stop),
    .load    (T4_CYC),
    .expired (t4_exp)
  );

  // ----------------------------------------
  // Phase sequencing
  // ----------------------------------------
  // all four criteria required
  assign ds_valid = qam_lock && fec_lock && mpeg_lock && sync_seen;

  always_comb begin
    s_d          = s_q;
    s_d.nv_write = 1'b0;
    s_d.extract  = 1'b0;
    s_d.range_go = 1'b0;
    s_d.upper_go = 1'b0;
    s_d.tune_go  = 1'b0;
    cif.clr      = 1'b0;
    cif.add      = 1'b0;
    cif.add_id   = ucd_chan_id;
    cif.next     = 1'b0;
    ucd_start    = 1'b0;
    t3_start     = 1'b0;
    t4_start     = 1'b0;
    tmr_stop     = 1'b0;
    if (sync_seen) begin
      s_d.time_ref = 1'b1;
    end
    // Lock judged at the settle pulse only; a late lock counts as a miss
    if (tune_done) begin
      s_d.tuning = 1'b0;
    end
    case (s_q.ph)
      init_seq_pkg::ST_STORED: begin
        if (!s_q.tuning) begin
          s_d.freq    = nv_valid ? nv_freq : BAND_LO;
          s_d.tune_go = 1'b1;
          s_d.tuning  = 1'b1;
        end else if (tune_done && ds_valid) begin
          s_d.ph    = init_seq_pkg::ST_WAITUCD;
          cif.clr   = 1'b1;
          ucd_start = 1'b1;
        end else if (tune_done) begin
          // Wraps so the first scan step lands on the band floor
          s_d.ph   = init_seq_pkg::ST_SCAN;
          s_d.freq = BAND_HI;
        end
      end
      // step through band in 6 MHz steps
      init_seq_pkg::ST_SCAN: begin
        if (!s_q.tuning) begin
          s_d.freq    = (s_q.freq >= BAND_HI) ? BAND_LO
                        : FREQ_W'(s_q.freq + FREQ_W'(`CHAN_STEP_KHZ));
          s_d.tune_go = 1'b1;
          s_d.tuning  = 1'b1;
        end else if (tune_done && ds_valid) begin
          s_d.ph    = init_seq_pkg::ST_WAITUCD;
          cif.clr   = 1'b1;
          ucd_start = 1'b1;
        end
      end
      init_seq_pkg::ST_WAITUCD: begin
        if (ucd_seen && ucd_usable) begin
          cif.add = 1'b1;
        end
        if (ucd_exp) begin
          if (cif.empty && !(ucd_seen && ucd_usable)) begin
            s_d.ph    = init_seq_pkg::ST_SCAN;
          end else begin
            s_d.ph = init_seq_pkg::ST_PICK;
          end
        end
      end
      init_seq_pkg::ST_PICK: begin
        if (cif.valid) begin
          s_d.chan    = cif.cur_id;
          s_d.extract = 1'b1;
          s_d.ph = s_q.time_ref ? init_seq_pkg::ST_WAITMAP
                                : init_seq_pkg::ST_SYNCTS;
        end else begin
          s_d.ph    = init_seq_pkg::ST_SCAN;
        end
      end
      init_seq_pkg::ST_SYNCTS: begin
        if (sync_seen) begin
          s_d.ph = init_seq_pkg::ST_WAITMAP;
        end
      end
      init_seq_pkg::ST_WAITMAP: begin
        if (map_seen && map_chan_id == s_q.chan) begin
          s_d.ph       = init_seq_pkg::ST_RANGE;
          s_d.tx_allow = 1'b1;
          s_d.range_go = 1'b1;
        end
      end
      init_seq_pkg::ST_RANGE: begin
        if (range_fail) begin
          s_d.ph       = init_seq_pkg::ST_PICK;
          s_d.tx_allow = 1'b0;
          cif.next     = 1'b1;
        end else if (range_ok) begin
          s_d.ph       = init_seq_pkg::ST_UPPER;
          s_d.upper_go = 1'b1;
        end
      end
      init_seq_pkg::ST_UPPER: begin
        if (upper_done) begin
          s_d.ph       = init_seq_pkg::ST_OPER;
          s_d.nv_write = 1'b1;
          t3_start     = 1'b1;
          t4_start     = 1'b1;
          s_d.t3_cnt   = '0;
        end
      end
      init_seq_pkg::ST_OPER, init_seq_pkg::ST_RESYNC: begin
        s_d.ph = (qam_lock && fec_lock && mpeg_lock) ? init_seq_pkg::ST_OPER
                                                     : init_seq_pkg::ST_RESYNC;
        if (t3_restart) begin
          t3_start   = 1'b1;
          s_d.t3_cnt = '0;
        end else if (t3_exp) begin
          s_d.t3_cnt = s_q.t3_cnt + 1'b1;
          t3_start   = 1'b1;
        end
        if (t4_restart) begin
          t4_start = 1'b1;
        end
        if (t4_exp || (t3_exp && !t3_restart && s_q.t3_cnt == `T3_LIMIT - 5'h01)) begin
          s_d.ph       = init_seq_pkg::ST_STORED;
          s_d.tuning   = 1'b0;
          s_d.tx_allow = 1'b0;
          s_d.time_ref = 1'b0;
          // Rearms in this cycle would outrank the stop
          t3_start     = 1'b0;
          t4_start     = 1'b0;
          tmr_stop     = 1'b1;
        end
      end
      default: begin
        s_d.ph = init_seq_pkg::ST_STORED;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_q     <= '0;
      s_q.ph  <= init_seq_pkg::ST_STORED;
      s_q.mac <= MAC_ADDR;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign nv_write    = s_q.nv_write;
  assign nv_wr_freq  = s_q.freq;
  assign tune_freq   = s_q.freq;
  assign tune_go     = s_q.tune_go;
  assign us_chan_id  = s_q.chan;
  assign ucd_extract = s_q.extract;
  assign tx_allow    = s_q.tx_allow;
  assign range_start = s_q.range_go;
  assign upper_start = s_q.upper_go;
  // scan indication
  // One-hot bits, so no decode after the flop
  assign scanning    = s_q.ph[1];
  assign operational = s_q.ph[8];
  assign mac_addr    = s_q.mac;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_map_before_tx;
    @(posedge clock) disable iff (!reset_n)
      $rose(s_q.tx_allow) |-> $past(map_seen && map_chan_id == s_q.chan);
  endproperty
  a_map_before_tx: assert property (p_map_before_tx) else $error("tx without map");

  property p_valid_gate;
    @(posedge clock) disable iff (!reset_n)
      (s_q.ph == init_seq_pkg::ST_SCAN && s_d.ph == init_seq_pkg::ST_WAITUCD) |-> ds_valid;
  endproperty
  a_valid_gate: assert property (p_valid_gate) else $error("sync without lock");

  property p_no_quick_reinit;
    @(posedge clock) disable iff (!reset_n)
      (s_q.ph == init_seq_pkg::ST_RESYNC && !t4_exp && !t3_exp) |=>
        s_q.ph != init_seq_pkg::ST_STORED;
  endproperty
  a_no_quick_reinit: assert property (p_no_quick_reinit) else $error("early reinit");

  property p_t4_reinit;
    @(posedge clock) disable iff (!reset_n)
      (t4_exp && (s_q.ph == init_seq_pkg::ST_OPER || s_q.ph == init_seq_pkg::ST_RESYNC))
        |=> s_q.ph == init_seq_pkg::ST_STORED;
  endproperty
  a_t4_reinit: assert property (p_t4_reinit) else $error("T4 ignored");

  property p_range_fail_next;
    @(posedge clock) disable iff (!reset_n)
      (s_q.ph == init_seq_pkg::ST_RANGE && range_fail) |=>
        (s_q.ph == init_seq_pkg::ST_PICK && !s_q.tx_allow);
  endproperty
  a_range_fail_next: assert property (p_range_fail_next) else $error("range fail path");

  property p_exhaust;
    @(posedge clock) disable iff (!reset_n)
      (s_q.ph == init_seq_pkg::ST_PICK && !cif.valid) |=> scanning;
  endproperty
  a_exhaust: assert property (p_exhaust) else $error("exhausted, no rescan");

  property p_ucd_timeout;
    @(posedge clock) disable iff (!reset_n)
      (s_q.ph == init_seq_pkg::ST_WAITUCD && ucd_exp && cif.empty && !ucd_seen) |=> scanning;
  endproperty
  a_ucd_timeout: assert property (p_ucd_timeout) else $error("no rescan on timeout");

  property p_order;
    @(posedge clock) disable iff (!reset_n)
      $rose(operational) |-> $past(s_q.ph == init_seq_pkg::ST_UPPER && upper_done);
  endproperty
  a_order: assert property (p_order) else $error("phase order broken");

  property p_mac_const;
    @(posedge clock) disable iff (!reset_n)
      1'b1 |=> mac_addr == MAC_ADDR;
  endproperty
  a_mac_const: assert property (p_mac_const) else $error("mac address changed");
endmodule
`default_nettype wire

// ==== rtl/phase_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
// Restartable one-shot timer
module phase_timer #(
  parameter int W = 32
) (
  // System
  input  wire logic         clock,
  input  wire logic         reset_n,
  // Control
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic [W-1:0] load,
  output logic              expired
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         run;
    logic         exp;
  } tmr_t;
  tmr_t t_q, t_d;

  always_comb begin
    t_d     = t_q;
    t_d.exp = 1'b0;
    if (start) begin
      t_d.cnt = load;
      t_d.run = 1'b1;
    end else if (stop) begin
      t_d.run = 1'b0;
    end else if (t_q.run) begin
      if (t_q.cnt <= 1) begin
        t_d.run = 1'b0;
        t_d.exp = 1'b1;
      end else begin
        t_d.cnt = t_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign expired = t_q.exp;

  // expiry only after a running count
  property p_exp_cause;
    @(posedge clock) disable iff (!reset_n)
      expired |-> $past(t_q.run);
  endproperty
  a_exp_cause: assert property (p_exp_cause) else $error("timer fired while idle");
endmodule
`default_nettype wire

// ==== sim/headend_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module headend_model #(
  parameter int ID_W   = 8,
  parameter int FREQ_W = 20
) (
  // System
  input  wire logic              clock,
  input  wire logic              reset_n,
  // Bench controls
  input  wire logic              cfg_ok,
  input  wire logic              carrier,
  input  wire logic [2:0]        usable_mask,
  input  wire logic [FREQ_W-1:0] good_freq,
  // Tuner side
  input  wire logic [FREQ_W-1:0] tune_freq,
  input  wire logic              tune_go,
  output logic                   tune_done,
  output logic                   qam_lock,
  output logic                   fec_lock,
  output logic                   mpeg_lock,
  // Downstream messages
  output logic                   sync_seen,
  output logic                   ucd_seen,
  output logic [ID_W-1:0]        ucd_chan_id,
  output logic                   ucd_usable
);
  // ------------------------------
  // Tuning and message schedule
  // ------------------------------
  logic [1:0]      pend_q;
  logic            tuned_q;
  logic [2:0]      tick_q;
  logic [1:0]      ix_q;
  logic            locked;
  logic [ID_W-1:0] id;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pend_q  <= 2'h0;
      tuned_q <= 1'b0;
      tick_q  <= 3'h0;
      ix_q    <= 2'h0;
    end else begin
      tick_q <= tick_q + 3'h1;
      if (tune_go) begin
        pend_q  <= 2'h3;
        tuned_q <= 1'b0;
      end else if (pend_q != 2'h0) begin
        pend_q <= pend_q - 2'h1;
        if (pend_q == 2'h2) begin
          tuned_q <= (tune_freq == good_freq);
        end
      end
      if (tick_q == 3'h4) begin
        ix_q <= (ix_q == 2'h2) ? 2'h0 : ix_q + 2'h1;
      end
    end
  end

  // Locks drop at once when the carrier goes, no grace period
  assign locked    = tuned_q & carrier;
  assign tune_done = (pend_q == 2'h1);
  assign qam_lock  = locked;
  assign fec_lock  = locked;
  assign mpeg_lock = locked;
  // silent unless stored config is valid
  assign sync_seen = cfg_ok & locked & (tune_done | (tick_q == 3'h0));
  assign ucd_seen  = cfg_ok & locked & (tick_q == 3'h4);
  assign id        = ID_W'(ix_q) + ID_W'(1);
  // Idle id lines show junk so a stale value is never trusted
  assign ucd_chan_id = ucd_seen ? id : ~id;
  assign ucd_usable  = ucd_seen ? usable_mask[ix_q] : tick_q[0];
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ------------------------------
  // Setup
  // ------------------------------
  localparam logic [47:0] MAC  = 48'h0200_0000_0001; // arbitrary value
  localparam logic [19:0] GOOD = 20'h0_4650;
  typedef struct packed {
    logic [19:0] freq;
    logic        scan;
  } row_t;
  logic        clock, reset_n, nv_valid, nv_write, tune_go, tune_done;
  logic        qam_lock, fec_lock, mpeg_lock, sync_seen, ucd_seen, ucd_usable;
  logic        map_seen, range_ok, range_fail, upper_done, ucd_extract, tx_allow;
  logic        range_start, upper_start, scanning, operational, cfg_ok, carrier;
  logic        t3_restart, t4_restart;
  logic [2:0]  usable_mask;
  logic [7:0]  ucd_chan_id, map_chan_id, us_chan_id;
  logic [19:0] nv_freq, nv_wr_freq, tune_freq;
  logic [47:0] mac_addr;
  int          n_fail, n_tests;
  row_t        rows [5];

  // short timers keep the run brief
  modem_init_sequencer #(.UCD_CYC(32'h0000_0020), .T3_CYC(32'h0000_000A),
    .T4_CYC(32'h0000_00C8), .BAND_LO(20'h0_0000), .BAND_HI(20'h0_7530),
    .MAC_ADDR(MAC)) dut (.clock(clock), .reset_n(reset_n), .nv_freq(nv_freq),
    .nv_valid(nv_valid), .nv_write(nv_write), .nv_wr_freq(nv_wr_freq),
    .tune_freq(tune_freq), .tune_go(tune_go), .tune_done(tune_done),
    .qam_lock(qam_lock), .fec_lock(fec_lock), .mpeg_lock(mpeg_lock),
    .sync_seen(sync_seen), .ucd_seen(ucd_seen), .ucd_chan_id(ucd_chan_id),
    .ucd_usable(ucd_usable), .map_seen(map_seen), .map_chan_id(map_chan_id),
    .range_ok(range_ok), .range_fail(range_fail), .t3_restart(t3_restart),
    .t4_restart(t4_restart), .upper_done(upper_done), .us_chan_id(us_chan_id),
    .ucd_extract(ucd_extract), .tx_allow(tx_allow), .range_start(range_start),
    .upper_start(upper_start), .scanning(scanning), .operational(operational),
    .mac_addr(mac_addr));

  headend_model peer (.clock(clock), .reset_n(reset_n), .cfg_ok(cfg_ok),
    .carrier(carrier), .usable_mask(usable_mask), .good_freq(GOOD),
    .tune_freq(tune_freq), .tune_go(tune_go), .tune_done(tune_done),
    .qam_lock(qam_lock), .fec_lock(fec_lock), .mpeg_lock(mpeg_lock),
    .sync_seen(sync_seen), .ucd_seen(ucd_seen), .ucd_chan_id(ucd_chan_id),
    .ucd_usable(ucd_usable));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic logic sig(input int k);
    case (k)
      0: return tune_go;
      1: return ucd_extract;
      2: return range_start;
      3: return upper_start;
      4: return nv_write;
      5: return scanning;
      6: return tx_allow;
      default: return operational;
    endcase
  endfunction

  task automatic results;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // Bounded wait; running out ends the run
  task automatic wait_sig(input int k, input int n, input logic v);
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      if (sig(k) === v) return;
    end
    check(1'b0, "wait ran out");
    results();
  endtask

  task automatic none_for(input int k, input int n, input logic v, input string msg);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      if (sig(k) === v) hit = 1'b1;
    end
    check(!hit, msg);
  endtask

  task automatic pulse(input int k, input logic [7:0] id);
    @(posedge clock);
    #1;
    map_chan_id = id;
    case (k)
      0: map_seen = 1'b1;
      1: range_ok = 1'b1;
      2: range_fail = 1'b1;
      default: upper_done = 1'b1;
    endcase
    @(posedge clock);
    #1;
    {map_seen, range_ok, range_fail, upper_done} = 4'h0;
    map_chan_id = ~id;
  endtask

  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    n_fail = 0;
    n_tests = 0;
    reset_n = 1'b0;
    nv_valid = 1'b1;
    nv_freq = 20'h0_2EE0;
    cfg_ok = 1'b1;
    carrier = 1'b1;
    usable_mask = 3'b110;
    {t3_restart, t4_restart} = 2'b00;
    {map_seen, range_ok, range_fail, upper_done} = 4'h0;
    map_chan_id = 8'h00;
    rows = '{'{20'h0_2EE0, 1'b0}, '{20'h0_0000, 1'b1}, '{20'h0_1770, 1'b1},
             '{20'h0_2EE0, 1'b1}, '{GOOD, 1'b1}};
    repeat (20) @(posedge clock);
    @(negedge clock);
    check(mac_addr === MAC && {tune_go, tx_allow, operational} === 3'h0, "reset");
    @(posedge clock);
    #1;
    reset_n = 1'b1;
    // Stored channel first, then the scan from the band floor
    for (int r = 0; r < 5; r++) begin
      wait_sig(0, 50, 1'b1);
      check(tune_freq === rows[r].freq, "tune frequency");
      check(scanning === rows[r].scan, "scan indication");
    end
    wait_sig(5, 20, 1'b0);
    wait_sig(1, 80, 1'b1);
    check(us_chan_id === 8'h02, "first usable id");
    check(tx_allow === 1'b0, "allowed before map");
    pulse(0, 8'h05);
    none_for(6, 8, 1'b1, "map for other id");
    pulse(0, 8'h02);
    wait_sig(2, 10, 1'b1);
    check(tx_allow === 1'b1, "no allowance after map");
    pulse(2, 8'h00);
    wait_sig(1, 20, 1'b1);
    check(us_chan_id === 8'h03 && tx_allow === 1'b0, "next id after fail");
    pulse(0, 8'h03);
    wait_sig(2, 10, 1'b1);
    pulse(1, 8'h00);
    wait_sig(3, 10, 1'b1);
    check(operational === 1'b0, "operational too early");
    pulse(3, 8'h00);
    wait_sig(4, 10, 1'b1);
    check(nv_wr_freq === GOOD, "stored frequency");
    wait_sig(7, 5, 1'b1);
    // Carrier loss: resync while ranging answers rearm both timers
    @(posedge clock);
    #1;
    nv_freq = GOOD;
    carrier = 1'b0;
    usable_mask = 3'b010;
    {t3_restart, t4_restart} = 2'b11;
    none_for(0, 300, 1'b1, "reinit while timers rearmed");
    check(operational === 1'b0, "resync not shown");
    @(posedge clock);
    #1;
    t3_restart = 1'b0;
    none_for(0, 100, 1'b1, "reinit too early");
    wait_sig(0, 400, 1'b1);
    check(tune_freq === GOOD, "reinit not at stored channel");
    @(posedge clock);
    #1;
    carrier = 1'b1;
    t4_restart = 1'b0;
    wait_sig(1, 80, 1'b1);
    check(us_chan_id === 8'h02, "only usable id");
    pulse(0, 8'h02);
    wait_sig(2, 10, 1'b1);
    pulse(2, 8'h00);
    wait_sig(5, 20, 1'b1);
    @(posedge clock);
    #1;
    usable_mask = 3'b000;
    wait_sig(5, 150, 1'b0);
    wait_sig(5, 80, 1'b1);
    @(posedge clock);
    #1;
    cfg_ok = 1'b0;
    none_for(5, 200, 1'b0, "left scan without sync");
    results();
  end
endmodule
`default_nettype wire
